// >>> bridge_ctrl_pkg.sv
// Purpose: Shared constants and types for the bridge control register bank
// Assumes: Byte offsets within configuration space, dword-wide access port
// Notes:   Lane and dword of each register are derived from its offset
package bridge_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ID_OFS           = 8'h00;
	localparam logic [7:0] DEV_CTRL_OFS     = 8'h92;
	localparam logic [7:0] DIAG_OFS         = 8'h93;
	localparam logic [7:0] CAP_ID_OFS       = 8'ha0;
	localparam logic [7:0] NEXT_PTR_OFS     = 8'ha1;

	// ----------------------------------------------------------------
	// Reset and fixed values
	// ----------------------------------------------------------------
	localparam logic [7:0]  DEV_CTRL_RESET   = 8'h66;
	localparam logic [7:0]  DIAG_RESET       = 8'h60;
	localparam logic [7:0]  CAP_ID_VALUE     = 8'h01;
	localparam logic [7:0]  NEXT_PTR_VALUE   = 8'h00;
	localparam logic [7:0]  DEV_CTRL_WR_MASK = 8'hef;
	localparam logic [7:0]  DIAG_WR_MASK     = 8'hbf;
	localparam logic [7:0]  DIAG_FORCE_ONE   = 8'h40;
	localparam logic [31:0] ALL_ONES_ID      = 32'hffffffff;
	localparam logic [1:0]  D3_STATE         = 2'h3;
	localparam logic [3:0]  LEGACY_805_PCI   = 4'h0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DC_HOLD_BIT   = 7;
	localparam int DC_LV_BIT     = 6;
	localparam int DC_DIAG_BIT   = 5;
	localparam int DC_MODE_LO    = 1;
	localparam int DG_MASK_BIT   = 7;
	localparam int DG_ROUTE_BIT  = 5;
	localparam int DG_DT_OFF_BIT = 4;
	localparam int DG_LAT_BIT    = 3;
	localparam int DG_CARD_BIT   = 2;
	localparam int DG_HOST_BIT   = 1;
	localparam int DG_VIDEO_BIT  = 0;

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam int LATENCY_SHORT      = 16;
	localparam int LATENCY_LONG       = 64;
	localparam int DISCARD_SHORT_LOG2 = 10;
	localparam int DISCARD_LONG_LOG2  = 15;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IRQ_PCI_PARALLEL,
		IRQ_PAR_PLUS_PCI,
		IRQ_SER_PLUS_PCI,
		IRQ_ALL_SERIAL
	} irq_mode_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  dword;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic parallel_pci;
		logic parallel_irq;
		logic serial_irq;
		logic serial_pci;
	} irq_route_t;

endpackage

// >>> retry_latency_timer.sv
// Purpose: Counts target latency of a pending request and flags a retry
// Assumes: active stays high while the request waits
// Notes:   Limit picked per cycle, so a change applies to the running count
`timescale 1ns/10ps
module retry_latency_timer
	import bridge_ctrl_pkg::*;
#(
	parameter int SHORT = LATENCY_SHORT,
	parameter int LONG  = LATENCY_LONG
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic active,
	input  wire logic extend,
	output logic      expired
);
	localparam int W = $clog2(LONG);
	logic [W-1:0] count;
	logic [W-1:0] limit;

	if (SHORT < 2 || SHORT >= LONG) begin : g_chk
		$error("retry_latency_timer: SHORT must be below LONG and at least 2");
	end

	assign limit = extend ? W'(LONG - 1) : W'(SHORT - 1);

	always_ff @(posedge clk_sys) begin
		if (!rst_b || !active) begin
			count   <= '0;
			expired <= 1'b0;
		end else if (count >= limit) begin
			count   <= '0;
			expired <= 1'b1;
		end else begin
			count   <= count + 1'b1;
			expired <= 1'b0;
		end
	end
endmodule

// >>> discard_timer.sv
// Purpose: Discards a delayed completion not collected in time
// Assumes: waiting is high from completion ready until the master returns
// Notes:   One pulse per expiry; the count restarts while still waiting
`timescale 1ns/10ps
module discard_timer
	import bridge_ctrl_pkg::*;
#(
	parameter int SHORT_LOG2 = DISCARD_SHORT_LOG2,
	parameter int LONG_LOG2  = DISCARD_LONG_LOG2
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic waiting,
	input  wire logic short_sel,
	output logic      discard
);
	logic [LONG_LOG2-1:0] count;
	logic [LONG_LOG2-1:0] limit;

	if (SHORT_LOG2 < 1 || SHORT_LOG2 >= LONG_LOG2) begin : g_chk
		$error("discard_timer: SHORT_LOG2 must be below LONG_LOG2");
	end

	assign limit = short_sel ? LONG_LOG2'((1 << SHORT_LOG2) - 1) : '1;

	always_ff @(posedge clk_sys) begin
		if (!rst_b || !waiting) begin
			count   <= '0;
			discard <= 1'b0;
		end else if (count >= limit) begin
			count   <= '0;
			discard <= 1'b1;
		end else begin
			count   <= count + 1'b1;
			discard <= 1'b0;
		end
	end
endmodule

// >>> bridge_device_control_regs.sv
// Purpose: Device control, diagnostic and capability head registers
// Assumes: Configuration accesses arrive as dword requests on clk_sys
// Notes:   Read data is registered and valid one cycle after the request
//
// Notes on behaviour
// [RULE1] Device control at 92h, reset 66h
// [RULE2] Power hold in D3 blocks socket removal
// [RULE3] Bit 6 forces reported 3-V capability
// [RULE4] Bit 5 diagnostic, read/write, resets 1
// [RULE5] Device control bit 4 reads zero
// [RULE6] Host writes only zero to bit 3
// [RULE7] Bits 2:1 select interrupt signaling mode
// [RULE8] Host writes only zero to bit 0
// [RULE9] Diagnostic at 93h, reset 60h, host writes 00h
// [RULE10] Bit 7 masks identifier reads to ones
// [RULE11] Diagnostic bit 6 always reads one
// [RULE12] Bit 5 picks status-change routing condition
// [RULE13] Diagnostic bit 4 disables delayed transactions
// [RULE14] Diagnostic bit 3 extends latency 16 to 64
// [RULE15] Bit 2 picks card discard timer length
// [RULE16] Bit 1 picks host discard timer length
// [RULE17] Bit 0 set disables video register model
// [RULE18] A0h always reads 01h
// [RULE19] A1h always reads 00h
// [RULE20] Writes never alter read-only values
`timescale 1ns/10ps
module bridge_device_control_regs
	import bridge_ctrl_pkg::*;
#(
	parameter logic [15:0] VENDOR_ID    = 16'h1234,
	parameter logic [15:0] DEVICE_ID    = 16'h5678,
	parameter int          DISCARD_LONG = DISCARD_LONG_LOG2
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire cfg_req_t   cfg_req,
	output logic [31:0]     cfg_rdata,
	output logic            cfg_rd_valid,
	input  wire logic       power_on_req,
	input  wire logic       power_off_req,
	input  wire logic [1:0] power_state,
	output logic            socket_power_en,
	output logic            power_off_refused,
	output logic            low_volt_capable,
	output logic            legacy_io_diag_bit,
	output irq_route_t      irq_route,
	input  wire logic       csc_event,
	input  wire logic       legacy_803_bit4,
	input  wire logic [3:0] legacy_805_irq_sel,
	output logic            csc_to_pci,
	output logic            csc_to_legacy,
	output logic            delayed_txn_enable,
	input  wire logic       host_retry_pending,
	output logic            retry_expired,
	input  wire logic       card_completion_wait,
	output logic            card_discard,
	input  wire logic       host_completion_wait,
	output logic            host_discard,
	output logic            std_video_model_en
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	localparam logic [5:0] ID_DW   = ID_OFS[7:2];
	localparam logic [5:0] CTRL_DW = DEV_CTRL_OFS[7:2];
	localparam logic [5:0] CAP_DW  = CAP_ID_OFS[7:2];
	localparam int         DC_LANE = int'(DEV_CTRL_OFS[1:0]);
	localparam int         DG_LANE = int'(DIAG_OFS[1:0]);
	localparam int         CI_LANE = int'(CAP_ID_OFS[1:0]);
	localparam int         NP_LANE = int'(NEXT_PTR_OFS[1:0]);

	logic [7:0]  device_control;
	logic [7:0]  diagnostic_options;
	logic [7:0]  diag_read;
	logic [31:0] next_rdata;
	logic        dc_write;
	logic        dg_write;
	logic        socket_locked;
	logic        csc_pci_cond;
	irq_mode_t   irq_mode;
	irq_route_t  next_route;

	if (DISCARD_LONG <= DISCARD_SHORT_LOG2) begin : g_chk
		$error("bridge_device_control_regs: DISCARD_LONG too small");
	end

	assign dc_write = cfg_req.wr && cfg_req.dword == CTRL_DW && cfg_req.be[DC_LANE];
	assign dg_write = cfg_req.wr && cfg_req.dword == CTRL_DW && cfg_req.be[DG_LANE];

	// ----------------------------------------------------------------
	// Device control register
	// ----------------------------------------------------------------
	// Bits 3 and 0 are stored as written; keeping them zero is up to software
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			device_control <= DEV_CTRL_RESET; // [RULE1] [RULE3] [RULE4] [RULE7]
		end else if (dc_write) begin
			// Reserved bit 4 is masked so it can never read back as one
			device_control <= cfg_req.wdata[8*DC_LANE +: 8] & DEV_CTRL_WR_MASK; // [RULE1] [RULE5] [RULE6] [RULE8]
		end
	end

	// ----------------------------------------------------------------
	// Diagnostic register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			diagnostic_options <= DIAG_RESET & DIAG_WR_MASK; // [RULE9]
		end else if (dg_write) begin
			diagnostic_options <= cfg_req.wdata[8*DG_LANE +: 8] & DIAG_WR_MASK; // [RULE9] [RULE20]
		end
	end

	assign diag_read = diagnostic_options | DIAG_FORCE_ONE; // [RULE11]

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Bytes 90h, 91h, A2h and A3h belong to neighbouring blocks and read zero
	always_comb begin
		next_rdata = '0;
		if (cfg_req.dword == ID_DW) begin
			if (diagnostic_options[DG_MASK_BIT]) begin
				next_rdata = ALL_ONES_ID; // [RULE10]
			end else begin
				next_rdata = {DEVICE_ID, VENDOR_ID}; // [RULE10]
			end
		end else if (cfg_req.dword == CTRL_DW) begin
			next_rdata[8*DC_LANE +: 8] = device_control;
			next_rdata[8*DG_LANE +: 8] = diag_read;
		end else if (cfg_req.dword == CAP_DW) begin
			next_rdata[8*CI_LANE +: 8] = CAP_ID_VALUE; // [RULE18] [RULE20]
			next_rdata[8*NP_LANE +: 8] = NEXT_PTR_VALUE; // [RULE19] [RULE20]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cfg_rdata    <= '0;
			cfg_rd_valid <= 1'b0;
		end else begin
			cfg_rd_valid <= cfg_req.rd;
			if (cfg_req.rd) begin
				cfg_rdata <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Socket power
	// ----------------------------------------------------------------
	// Lock only bites in D3; removal in other states goes through
	assign socket_locked = device_control[DC_HOLD_BIT] && power_state == D3_STATE;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			socket_power_en   <= 1'b0;
			power_off_refused <= 1'b0;
		end else begin
			power_off_refused <= power_off_req && socket_locked; // [RULE2]
			if (power_off_req && !socket_locked) begin
				socket_power_en <= 1'b0; // [RULE2]
			end else if (power_on_req) begin
				socket_power_en <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Capability and interrupt mode
	// ----------------------------------------------------------------
	assign irq_mode = irq_mode_t'(device_control[DC_MODE_LO +: 2]);

	always_comb begin
		next_route = '0;
		case (irq_mode)
			IRQ_PCI_PARALLEL: begin
				next_route.parallel_pci = 1'b1; // [RULE7]
			end
			IRQ_PAR_PLUS_PCI: begin
				next_route.parallel_pci = 1'b1; // [RULE7]
				next_route.parallel_irq = 1'b1;
			end
			IRQ_SER_PLUS_PCI: begin
				next_route.parallel_pci = 1'b1; // [RULE7]
				next_route.serial_irq   = 1'b1;
			end
			default: begin
				next_route.serial_irq = 1'b1; // [RULE7]
				next_route.serial_pci = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_route          <= '0;
			low_volt_capable   <= 1'b0;
			legacy_io_diag_bit <= 1'b0;
		end else begin
			irq_route          <= next_route;
			low_volt_capable   <= device_control[DC_LV_BIT]; // [RULE3]
			legacy_io_diag_bit <= device_control[DC_DIAG_BIT]; // [RULE4]
		end
	end

	// ----------------------------------------------------------------
	// Status-change interrupt routing
	// ----------------------------------------------------------------
	// With routing bit set the 803 enable is deliberately not looked at
	assign csc_pci_cond = diagnostic_options[DG_ROUTE_BIT]
		? (legacy_805_irq_sel == LEGACY_805_PCI)
		: legacy_803_bit4; // [RULE12]

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			csc_to_pci    <= 1'b0;
			csc_to_legacy <= 1'b0;
		end else begin
			csc_to_pci    <= csc_event && csc_pci_cond; // [RULE12]
			csc_to_legacy <= csc_event && !csc_pci_cond;
		end
	end

	// ----------------------------------------------------------------
	// Delayed transactions and options
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			delayed_txn_enable <= 1'b0;
			std_video_model_en <= 1'b0;
		end else begin
			delayed_txn_enable <= !diagnostic_options[DG_DT_OFF_BIT]; // [RULE13]
			std_video_model_en <= !diagnostic_options[DG_VIDEO_BIT]; // [RULE17]
		end
	end

	// Timers stop at once when delayed handling is switched off
	retry_latency_timer #(
		.SHORT (LATENCY_SHORT),
		.LONG  (LATENCY_LONG)
	) u_retry (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.active  (host_retry_pending && !diagnostic_options[DG_DT_OFF_BIT]), // [RULE13]
		.extend  (diagnostic_options[DG_LAT_BIT]), // [RULE14]
		.expired (retry_expired)
	);

	discard_timer #(
		.SHORT_LOG2 (DISCARD_SHORT_LOG2),
		.LONG_LOG2  (DISCARD_LONG)
	) u_card_discard (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.waiting   (card_completion_wait && !diagnostic_options[DG_DT_OFF_BIT]),
		.short_sel (diagnostic_options[DG_CARD_BIT]), // [RULE15]
		.discard   (card_discard)
	);

	discard_timer #(
		.SHORT_LOG2 (DISCARD_SHORT_LOG2),
		.LONG_LOG2  (DISCARD_LONG)
	) u_host_discard (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.waiting   (host_completion_wait && !diagnostic_options[DG_DT_OFF_BIT]),
		.short_sel (diagnostic_options[DG_HOST_BIT]), // [RULE16]
		.discard   (host_discard)
	);

endmodule

// >>> bridge_device_control_regs_assertions.sv
// Purpose: Concurrent checks on the control register bank ports
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Rules needing stored register state are left to the bench
`timescale 1ns/10ps
module bridge_device_control_regs_assertions
	import bridge_ctrl_pkg::*;
#(
	parameter logic [15:0] VENDOR_ID = 16'h1234,
	parameter logic [15:0] DEVICE_ID = 16'h5678
) (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire cfg_req_t    cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_rd_valid,
	input wire logic        power_off_req,
	input wire logic [1:0]  power_state,
	input wire logic        socket_power_en,
	input wire logic        power_off_refused,
	input wire logic        csc_event,
	input wire logic        legacy_803_bit4,
	input wire logic [3:0]  legacy_805_irq_sel,
	input wire logic        csc_to_pci,
	input wire logic        csc_to_legacy,
	input wire logic        host_retry_pending,
	input wire logic        retry_expired
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire rd24 = cfg_req.rd && cfg_req.dword == 6'h24;
	wire rd28 = cfg_req.rd && cfg_req.dword == 6'h28;
	wire rd00 = cfg_req.rd && cfg_req.dword == 6'h00;
	wire off_in_d3 = power_off_req && power_state == 2'h3;
	wire sel_zero = legacy_805_irq_sel == 4'h0;
	chk_read_answer: assert property (cfg_req.rd |=> cfg_rd_valid)
		else $error("read not answered");
	chk_valid_cause: assert property (cfg_rd_valid |-> $past(cfg_req.rd))
		else $error("read valid without request");
	chk_ctrl_reserved: assert property (rd24 |=> !cfg_rdata[20])
		else $error("control bit 4 not zero");
	chk_diag_fixed_one: assert property (rd24 |=> cfg_rdata[30])
		else $error("diagnostic bit 6 not one");
	chk_cap_head: assert property (rd28 |=> cfg_rdata[15:0] == 16'h0001)
		else $error("capability head wrong");
	chk_id_view: assert property (rd00 |=> cfg_rdata == 32'hffffffff || cfg_rdata == {DEVICE_ID, VENDOR_ID})
		else $error("identifier read wrong");
	// A refused removal may meet a socket that was already off, so only a drop is wrong
	chk_lock_refuse: assert property (power_off_refused |-> $past(off_in_d3) && !$fell(socket_power_en))
		else $error("refusal without cause");
	chk_off_unlocked: assert property (power_off_req && power_state != 2'h3 |=> !socket_power_en)
		else $error("power not removed");
	chk_csc_single: assert property (csc_event |=> csc_to_pci != csc_to_legacy)
		else $error("status change not routed once");
	chk_csc_legacy: assert property (csc_event && !sel_zero && !legacy_803_bit4 |=> csc_to_legacy)
		else $error("status change wrongly to host");
	chk_csc_pci: assert property (csc_event && sel_zero && legacy_803_bit4 |=> csc_to_pci)
		else $error("status change not to host");
	chk_retry_spacing: assert property (retry_expired |-> $past(host_retry_pending) ##1 !retry_expired [*8])
		else $error("retry expiry too close");
endmodule

bind bridge_device_control_regs bridge_device_control_regs_assertions #(.VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID))
	chk_i (.clk_sys, .rst_b, .cfg_req, .cfg_rdata, .cfg_rd_valid, .power_off_req, .power_state, .socket_power_en,
	.power_off_refused, .csc_event, .legacy_803_bit4, .legacy_805_irq_sel, .csc_to_pci, .csc_to_legacy,
	.host_retry_pending, .retry_expired);

// >>> cfg_host_model.sv
// Purpose: Host issuing configuration reads and writes
// Assumes: One access at a time, read answered one cycle later
// Notes:   Released lines show inverted values, never stale ones
`timescale 1ns/10ps
module cfg_host_model
	import bridge_ctrl_pkg::*;
(
	input  wire logic        clk_sys,
	output cfg_req_t         cfg_req,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_rd_valid
);
	initial cfg_req = '0;
	task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk_sys);
		cfg_req <= {2'b10, dw, be, d & ~32'h00090000};
		@(posedge clk_sys);
		cfg_req <= {2'b00, ~dw, ~be, ~d};
	endtask
	task automatic rd(input logic [5:0] dw, output logic [31:0] q, output logic ok);
		@(posedge clk_sys);
		cfg_req <= {2'b01, dw, 4'hf, 32'h0};
		@(posedge clk_sys);
		cfg_req <= {2'b00, ~dw, 4'h0, 32'hffffffff};
		#1;
		ok = cfg_rd_valid;
		q  = cfg_rdata;
	endtask
endmodule

// >>> bridge_device_control_regs_bench.sv
// Purpose: Self-checking bench for the control register bank
// Assumes: Long discard count shortened to 2^11
// Notes:   Timer figures checked from one cycle under to two cycles over
`timescale 1ns/10ps
module bridge_device_control_regs_bench;
	import bridge_ctrl_pkg::*;
	logic        clk_sys, rst_b, power_on_req, power_off_req, csc_event, legacy_803_bit4;
	logic        host_retry_pending, card_completion_wait, host_completion_wait, cfg_rd_valid, ok;
	logic        socket_power_en, power_off_refused, low_volt_capable, legacy_io_diag_bit, csc_to_pci;
	logic        csc_to_legacy, delayed_txn_enable, retry_expired, card_discard, host_discard;
	logic        std_video_model_en;
	logic [1:0]  power_state;
	logic [3:0]  legacy_805_irq_sel;
	logic [31:0] cfg_rdata, q;
	cfg_req_t    cfg_req;
	irq_route_t  irq_route;
	int          failures, total_checks, n;
	const logic [3:0] route_exp [4] = '{4'h8, 4'hc, 4'ha, 4'h3};

	bridge_device_control_regs #(.DISCARD_LONG(11)) bridge_device_control_regs_i (.clk_sys, .rst_b, .cfg_req,
		.cfg_rdata, .cfg_rd_valid, .power_on_req, .power_off_req, .power_state, .socket_power_en, .power_off_refused,
		.low_volt_capable, .legacy_io_diag_bit, .irq_route, .csc_event, .legacy_803_bit4, .legacy_805_irq_sel,
		.csc_to_pci, .csc_to_legacy, .delayed_txn_enable, .host_retry_pending, .retry_expired, .card_completion_wait,
		.card_discard, .host_completion_wait, .host_discard, .std_video_model_en);
	cfg_host_model cfg_host_model_i (.clk_sys, .cfg_req, .cfg_rdata, .cfg_rd_valid);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("failures=%0d total_checks=%0d", failures, total_checks);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [5:0] dw, input logic [31:0] exp);
		cfg_host_model_i.rd(dw, q, ok);
		chk(ok, 1'b1);
		chk(q, exp);
	endtask
	task automatic setregs(input logic [7:0] dev, input logic [7:0] diag);
		cfg_host_model_i.wr(6'h24, 4'hc, {diag, dev, 16'h0});
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	// Counts cycles from raising a wait input to its expiry pulse
	task automatic tmeas(input int w, input int lim, input bit must);
		@(posedge clk_sys);
		host_retry_pending   <= (w == 0);
		card_completion_wait <= (w == 1);
		host_completion_wait <= (w == 2);
		for (n = 1; n <= lim; n++) begin
			@(posedge clk_sys);
			#1;
			if ((w == 0) ? retry_expired : (w == 1) ? card_discard : host_discard)
				break;
		end
		@(posedge clk_sys);
		{host_retry_pending, card_completion_wait, host_completion_wait} <= 3'b000;
		if (must && n > lim) begin
			failures++;
			$display("ERROR %0t: expiry not seen within limit", $time);
			stop_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_b, power_on_req, power_off_req, csc_event, legacy_803_bit4} = '0;
		{host_retry_pending, card_completion_wait, host_completion_wait, power_state, legacy_805_irq_sel} = '0;
		failures = 0;
		total_checks = 0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		rdchk(6'h24, 32'h60660000);
		chk({low_volt_capable, legacy_io_diag_bit, irq_route}, 6'h33);
		chk({delayed_txn_enable, std_video_model_en}, 2'h3);
		rdchk(6'h00, 32'h56781234);
		rdchk(6'h30, 32'h0);
		setregs(8'hf6, 8'hff);
		rdchk(6'h24, 32'hffe60000);
		chk({delayed_txn_enable, std_video_model_en}, 2'h0);
		rdchk(6'h00, 32'hffffffff);
		cfg_host_model_i.wr(6'h28, 4'hf, 32'hffffffff);
		cfg_host_model_i.rd(6'h28, q, ok);
		chk(ok, 1'b1);
		chk(q[15:0], 16'h0001);
		for (int m = 0; m < 4; m++) begin
			setregs({5'h0, m[1:0], 1'b0}, 8'h00);
			chk(irq_route, route_exp[m]);
			chk({low_volt_capable, legacy_io_diag_bit}, 2'h0);
		end
		for (int k = 0; k < 3; k++) begin
			setregs((k < 2) ? 8'h80 : 8'h00, 8'h00);
			@(posedge clk_sys) power_on_req <= 1'b1;
			@(posedge clk_sys) power_on_req <= 1'b0;
			power_off_req <= 1'b1;
			power_state <= (k == 1) ? 2'h0 : 2'h3;
			@(posedge clk_sys) power_off_req <= 1'b0;
			#1;
			chk({power_off_refused, socket_power_en}, (k == 0) ? 2'h3 : 2'h0);
		end
		for (int i = 0; i < 4; i++) begin
			setregs(8'h00, i[1] ? 8'h00 : 8'h20);
			@(posedge clk_sys) csc_event <= 1'b1;
			legacy_805_irq_sel <= i[0] ? 4'h8 : 4'h0;
			legacy_803_bit4 <= i[0] ^ i[1];
			@(posedge clk_sys) csc_event <= 1'b0;
			#1;
			chk({csc_to_pci, csc_to_legacy}, i[0] ? 2'h1 : 2'h2);
		end
		tmeas(0, 20, 1);
		chk(n inside {[15:18]}, 1'b1);
		setregs(8'h00, 8'h08);
		tmeas(0, 70, 1);
		chk(n inside {[63:66]}, 1'b1);
		setregs(8'h00, 8'h10);
		tmeas(0, 80, 0);
		chk(n, 81);
		for (int t = 0; t < 4; t++) begin
			setregs(8'h00, t[0] ? 8'h00 : (t[1] ? 8'h02 : 8'h04));
			tmeas(t[1] + 1, 2100, 1);
			chk(n >= (t[0] ? 2047 : 1023) && n <= (t[0] ? 2050 : 1026), 1'b1);
		end
		// Mid-run reset must bring back the reset values over the written ones
		@(posedge clk_sys) rst_b <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		rdchk(6'h24, 32'h60660000);
		chk({low_volt_capable, legacy_io_diag_bit, irq_route}, 6'h33);
		stop_test();
	end
endmodule
